// [hdl/sam_alarm_mapper.sv]
// Status alarm output mapper: eight configurable alarm lines, Avalon slave.
//
// Added by the designer: the Avalon-MM interface to the registers and the placing of the registers.
`timescale 1ns/1ns
`default_nettype none

module sam_alarm_mapper
	import sam_pkg::*;
(
	input  wire logic                           mclk_i,
	input  wire logic                           arst_n_i,
	input  wire logic [SAM_ADDR_W-1:0]          avs_address_i,
	input  wire logic                           avs_read_i,
	input  wire logic                           avs_write_i,
	input  wire logic [SAM_BE_W-1:0]            avs_byteenable_i,
	input  wire logic [SAM_DATA_W-1:0]          avs_writedata_i,
	output logic [SAM_DATA_W-1:0]               avs_readdata_o,
	output logic                                avs_waitrequest_o,
	input  wire sam_cond_in_s                   cond_i,
	input  wire logic [SAM_CHANS-1:0][SAM_RD_W-1:0] reading_i,
	output logic [SAM_LINES-1:0]                alarm_line_o
);

	// Bus slave state.
	logic                  ack_d;
	logic                  ack_q;
	logic                  wait_d;
	logic                  wait_q;
	logic [SAM_DATA_W-1:0] rdata_d;
	logic [SAM_DATA_W-1:0] rdata_q;

	// Configuration registers.
	sam_line_cfg_s [SAM_LINES-1:0]              cfg_d;
	sam_line_cfg_s [SAM_LINES-1:0]              cfg_q;
	logic          [SAM_CHANS-1:0][SAM_RD_W-1:0] range_d;
	logic          [SAM_CHANS-1:0][SAM_RD_W-1:0] range_q;
	logic          [SAM_CHANS-1:0]              ovren_d;
	logic          [SAM_CHANS-1:0]              ovren_q;

	// Condition synchroniser stages and the accepted value.
	logic [SAM_COND_W-1:0] sync1_q;
	logic [SAM_COND_W-1:0] sync2_q;
	logic [SAM_COND_W-1:0] sync3_q;
	logic [SAM_COND_W-1:0] stable_d;
	logic [SAM_COND_W-1:0] stable_q;
	sam_cond_in_s          cond_s;

	// Derived conditions and line state.
	logic [SAM_CHANS-1:0]  ovr_act;
	logic                  sys_fault_any;
	logic [SAM_LINES-1:0]  asserted;
	logic [SAM_LINES-1:0]  line_d;
	logic [SAM_LINES-1:0]  line_q;
	logic [SAM_LINES-1:0]  assrt_q;
	logic [SAM_DATA_W-1:0] cond_vec;

	// Bus decode helpers.
	logic                  wr_fire;
	logic [SAM_DATA_W-1:0] wmask;
	logic [SAM_DATA_W-1:0] old_word;
	logic [SAM_DATA_W-1:0] new_word;
	logic [SAM_ADDR_W-1:0] word_addr;
	logic                  is_cfg;
	logic [2:0]            cfg_idx;

	// Waitrequest handshake: every access is answered one cycle after it
	// is seen, and the write lands on the edge that samples waitrequest low.
	always_comb
	begin
		ack_d   = (avs_read_i || avs_write_i) && !ack_q;
		wait_d  = !ack_d;
		wr_fire = avs_write_i && ack_q;
	end

	// Waitrequest has its own flop so the pin carries no gate after it.
	always_ff @(posedge mclk_i or negedge arst_n_i)
	begin
		if (!arst_n_i)
		begin
			ack_q  <= 1'b0;
			wait_q <= 1'b1;
		end
		else
		begin
			ack_q  <= ack_d;
			wait_q <= wait_d;
		end
	end

	// Address decode; the two low address bits never select a register.
	always_comb
	begin
		word_addr = {avs_address_i[SAM_ADDR_W-1:SAM_WORD_LSB],
			{SAM_WORD_LSB{1'b0}}};
		is_cfg    = !avs_address_i[SAM_CFG_SEG];
		cfg_idx   = avs_address_i[SAM_CFG_SEG-1:SAM_WORD_LSB];
	end

	// Byte lane mask built from the byte enables.
	always_comb
	begin
		for (int b = 0; b < SAM_BE_W; b++)
			wmask[b*SAM_BYTE_W +: SAM_BYTE_W] =
				{SAM_BYTE_W{avs_byteenable_i[b]}};
	end

	// Condition vector as seen by software, in selector code order.
	always_comb
	begin
		cond_vec = '0;
		cond_vec[COND_PWR_SUPPLY +: SAM_FAULTS] = cond_s.fault;
		cond_vec[COND_USB_OFF]      = !cond_s.usb_present;
		cond_vec[COND_BACKGROUND]   = cond_s.background;
		cond_vec[COND_SPAN]         = cond_s.span;
		cond_vec[COND_ZERO]         = cond_s.zero;
		cond_vec[COND_SYS_FAULT]    = sys_fault_any;
		cond_vec[COND_MAINT]        = cond_s.maint;
		cond_vec[COND_OVR0 +: SAM_CHANS] = ovr_act;
	end

	// Current contents of the addressed word, zero where nothing is mapped.
	always_comb
	begin
		old_word = '0;
		if (is_cfg)
		begin
			old_word[SAM_CFG_SEL_LSB +: $bits(sam_cond_e)] =
				cfg_q[cfg_idx].sel;
			old_word[SAM_CFG_POL_BIT] = cfg_q[cfg_idx].active_high;
		end
		else
		begin
			case (word_addr)
				SAM_OFF_LINES:
				begin
					old_word[SAM_LINES_LVL_LSB +: SAM_LINES]   = line_q;
					old_word[SAM_LINES_ASSRT_LSB +: SAM_LINES] = assrt_q;
				end
				SAM_OFF_CONDS:  old_word = cond_vec;
				SAM_OFF_RANGE0: old_word[SAM_RD_W-1:0] = range_q[0];
				SAM_OFF_RANGE1: old_word[SAM_RD_W-1:0] = range_q[1];
				SAM_OFF_RANGE2: old_word[SAM_RD_W-1:0] = range_q[2];
				SAM_OFF_OVREN:  old_word[SAM_CHANS-1:0] = ovren_q;
				default:        old_word = '0;
			endcase
		end
		new_word = (old_word & ~wmask) | (avs_writedata_i & wmask);
	end

	// Read data is captured with the answer and held until the next one.
	always_comb
	begin
		rdata_d = rdata_q;
		if (ack_d && avs_read_i)
			rdata_d = old_word;
	end

	always_ff @(posedge mclk_i or negedge arst_n_i)
	begin
		if (!arst_n_i)
			rdata_q <= '0;
		else
			rdata_q <= rdata_d;
	end

	// Register writes; status words and unmapped offsets ignore writes.
	always_comb
	begin
		cfg_d   = cfg_q;
		range_d = range_q;
		ovren_d = ovren_q;
		if (wr_fire)
		begin
			if (is_cfg)
			begin
				cfg_d[cfg_idx].sel = sam_cond_e'(
					new_word[SAM_CFG_SEL_LSB +: $bits(sam_cond_e)]);
				cfg_d[cfg_idx].active_high =
					new_word[SAM_CFG_POL_BIT];
			end
			else
			begin
				case (word_addr)
					SAM_OFF_RANGE0: range_d[0] = new_word[SAM_RD_W-1:0];
					SAM_OFF_RANGE1: range_d[1] = new_word[SAM_RD_W-1:0];
					SAM_OFF_RANGE2: range_d[2] = new_word[SAM_RD_W-1:0];
					SAM_OFF_OVREN:  ovren_d = new_word[SAM_CHANS-1:0];
					default:        ovren_d = ovren_q;
				endcase
			end
		end
	end

	always_ff @(posedge mclk_i or negedge arst_n_i)
	begin
		if (!arst_n_i)
		begin
			for (int i = 0; i < SAM_LINES; i++)
			begin
				cfg_q[i].sel         <= COND_DISABLED;
				cfg_q[i].active_high <= SAM_POL_RESET;
			end
			range_q <= {SAM_CHANS{SAM_RANGE_RESET}};
			ovren_q <= SAM_OVREN_RESET;
		end
		else
		begin
			cfg_q   <= cfg_d;
			range_q <= range_d;
			ovren_q <= ovren_d;
		end
	end

	// Pin conditions cross into the clock domain through three stages; a
	// change is accepted only once stages two and three agree, which
	// rejects a level caught mid-transition.
	always_comb
	begin
		stable_d = stable_q;
		if (sync2_q == sync3_q)
			stable_d = sync3_q;
	end

	always_ff @(posedge mclk_i or negedge arst_n_i)
	begin
		if (!arst_n_i)
		begin
			sync1_q  <= '0;
			sync2_q  <= '0;
			sync3_q  <= '0;
			stable_q <= '0;
		end
		else
		begin
			sync1_q  <= cond_i;
			sync2_q  <= sync1_q;
			sync3_q  <= sync2_q;
			stable_q <= stable_d;
		end
	end

	assign cond_s = sam_cond_in_s'(stable_q);

	// One hysteresis detector per analog output channel.
	for (genvar c = 0; c < SAM_CHANS; c++)
	begin : g_ovr
		sam_ovr_hyst #(
			.W(SAM_RD_W)
		) u_ovr (
			.mclk_i    (mclk_i),
			.arst_n_i  (arst_n_i),
			.enable_i  (ovren_q[c]),
			.reading_i (reading_i[c]),
			.range_i   (range_q[c]),
			.active_o  (ovr_act[c])
		);
	end

	// The combined fault follows the panel fault input or any single fault.
	assign sys_fault_any = cond_s.sys_fault || (|cond_s.fault);

	// Condition selection and polarity per line.
	always_comb
	begin
		for (int i = 0; i < SAM_LINES; i++)
		begin
			case (cfg_q[i].sel)
				COND_DISABLED:     asserted[i] = 1'b0;
				COND_PWR_SUPPLY,
				COND_REF_VOLT,
				COND_CONVERTER,
				COND_LAMP,
				COND_FLOW,
				COND_FLOW_HEAT,
				COND_LAMP_HEAT,
				COND_CHASSIS_TEMP: asserted[i] = cond_vec[cfg_q[i].sel];
				COND_USB_OFF:      asserted[i] = !cond_s.usb_present;
				COND_BACKGROUND:   asserted[i] = cond_s.background;
				COND_SPAN:         asserted[i] = cond_s.span;
				COND_ZERO:         asserted[i] = cond_s.zero;
				COND_MAINT:        asserted[i] = cond_s.maint;
				COND_SYS_FAULT:    asserted[i] = sys_fault_any;
				COND_OVR0:         asserted[i] = ovr_act[0];
				COND_OVR1:         asserted[i] = ovr_act[1];
				COND_OVR2:         asserted[i] = ovr_act[2];
				default:           asserted[i] = 1'b0;
			endcase
			line_d[i] = cfg_q[i].active_high ? asserted[i]
				: !asserted[i];
		end
	end

	// Line outputs are registered; reset holds every line low.
	always_ff @(posedge mclk_i or negedge arst_n_i)
	begin
		if (!arst_n_i)
		begin
			line_q  <= '0;
			assrt_q <= '0;
		end
		else
		begin
			line_q  <= line_d;
			assrt_q <= asserted;
		end
	end

	// Outputs straight from flip-flops.
	assign alarm_line_o      = line_q;
	assign avs_readdata_o    = rdata_q;
	assign avs_waitrequest_o = wait_q;

endmodule : sam_alarm_mapper

`default_nettype wire

// [hdl/sam_ovr_hyst.sv]
// Over-range detector with hysteresis for one analog output channel.
`timescale 1ns/1ns
`default_nettype none

module sam_ovr_hyst
	import sam_pkg::*;
#(
	parameter int W = SAM_RD_W
)(
	input  wire logic         mclk_i,
	input  wire logic         arst_n_i,
	input  wire logic         enable_i,
	input  wire logic [W-1:0] reading_i,
	input  wire logic [W-1:0] range_i,
	output logic              active_o
);

	// Seven extra bits hold a product with one hundred.
	localparam int PW = W + 7;

	logic [PW-1:0] rd_scaled;
	logic [PW-1:0] set_lvl;
	logic [PW-1:0] clr_lvl;
	logic          active_d;
	logic          active_q;

	// Compare in percent without a divider: reading*100 against range*pct.
	always_comb
	begin
		rd_scaled = PW'(reading_i) * PW'(SAM_PCT_FULL);
		set_lvl   = PW'(range_i) * PW'(SAM_OVR_SET_PCT);
		clr_lvl   = PW'(range_i) * PW'(SAM_OVR_CLR_PCT);
		active_d  = active_q;
		if (!enable_i)
			active_d = 1'b0;
		else if (!active_q && rd_scaled >= set_lvl)
			active_d = 1'b1;
		else if (active_q && rd_scaled <= clr_lvl)
			active_d = 1'b0;
	end

	// State register.
	always_ff @(posedge mclk_i or negedge arst_n_i)
	begin
		if (!arst_n_i)
			active_q <= 1'b0;
		else
			active_q <= active_d;
	end

	assign active_o = active_q;

endmodule : sam_ovr_hyst

`default_nettype wire

// [hdl/sam_pkg.sv]
// Constants, register map and carrier types of the status alarm output mapper.
package sam_pkg;

	// Structure sizes.
	localparam int SAM_LINES  = 8;
	localparam int SAM_CHANS  = 3;
	localparam int SAM_FAULTS = 8;
	localparam int SAM_RD_W   = 16;
	localparam int SAM_ADDR_W = 6;
	localparam int SAM_DATA_W = 32;
	localparam int SAM_BE_W   = 4;
	localparam int SAM_BYTE_W = 8;
	localparam int SAM_SYNC_N = 3;

	// Register byte offsets; line n configuration sits at SAM_OFF_CFG0 + 4n.
	localparam logic [SAM_ADDR_W-1:0] SAM_OFF_CFG0   = 6'h00;
	localparam logic [SAM_ADDR_W-1:0] SAM_OFF_LINES  = 6'h20;
	localparam logic [SAM_ADDR_W-1:0] SAM_OFF_CONDS  = 6'h24;
	localparam logic [SAM_ADDR_W-1:0] SAM_OFF_RANGE0 = 6'h28;
	localparam logic [SAM_ADDR_W-1:0] SAM_OFF_RANGE1 = 6'h2C;
	localparam logic [SAM_ADDR_W-1:0] SAM_OFF_RANGE2 = 6'h30;
	localparam logic [SAM_ADDR_W-1:0] SAM_OFF_OVREN  = 6'h34;

	// Word index fields inside the byte address.
	localparam int SAM_WORD_LSB = 2;
	localparam int SAM_CFG_SEG  = 5;

	// Field positions.
	localparam int SAM_CFG_SEL_LSB     = 0;
	localparam int SAM_CFG_POL_BIT     = 8;
	localparam int SAM_LINES_LVL_LSB   = 0;
	localparam int SAM_LINES_ASSRT_LSB = 8;

	// Reset values.
	localparam logic                SAM_POL_RESET   = 1'b1;
	localparam logic [SAM_RD_W-1:0] SAM_RANGE_RESET = 16'hFFFF;
	localparam logic [SAM_CHANS-1:0] SAM_OVREN_RESET = 3'h7;

	// Over-range hysteresis thresholds in percent of the standard range.
	localparam int SAM_PCT_FULL    = 100;
	localparam int SAM_OVR_SET_PCT = 90;
	localparam int SAM_OVR_CLR_PCT = 80;

	// Selectable alarm conditions, in selector code order.
	typedef enum logic [4:0] {
		COND_DISABLED,
		COND_PWR_SUPPLY,
		COND_REF_VOLT,
		COND_CONVERTER,
		COND_LAMP,
		COND_FLOW,
		COND_FLOW_HEAT,
		COND_LAMP_HEAT,
		COND_CHASSIS_TEMP,
		COND_USB_OFF,
		COND_BACKGROUND,
		COND_SPAN,
		COND_ZERO,
		COND_SYS_FAULT,
		COND_MAINT,
		COND_OVR0,
		COND_OVR1,
		COND_OVR2
	} sam_cond_e;

	// Per-line configuration.
	typedef struct packed {
		logic      active_high;
		sam_cond_e sel;
	} sam_line_cfg_s;

	// Instrument condition inputs, fault bits in condition order 1..8.
	typedef struct packed {
		logic                  maint;
		logic                  sys_fault;
		logic                  zero;
		logic                  span;
		logic                  background;
		logic                  usb_present;
		logic [SAM_FAULTS-1:0] fault;
	} sam_cond_in_s;

	localparam int SAM_COND_W = $bits(sam_cond_in_s);

endpackage : sam_pkg

// [test/sam_alarm_logger.sv]
// Model of the external alarm logger that polls the alarm lines.
`timescale 1ns/1ns
`default_nettype none

module sam_alarm_logger
	import sam_pkg::*;
(
	input  wire logic                 mclk_i,
	input  wire logic [SAM_LINES-1:0] line_i,
	output logic [SAM_LINES-1:0]      seen_o
);
	// The logger latches the line levels on every rising clock edge.
	always_ff @(posedge mclk_i)
		seen_o <= line_i;
endmodule : sam_alarm_logger

`default_nettype wire

// [test/sam_alarm_mapper_chk.sv]
// Checker for the alarm mapper bus handshake and alarm line behaviour.
`timescale 1ns/1ns
`default_nettype none

module sam_alarm_mapper_chk
	import sam_pkg::*;
(
	input  wire logic                               mclk_i,
	input  wire logic                               arst_n_i,
	input  wire logic [SAM_ADDR_W-1:0]              avs_address_i,
	input  wire logic                               avs_read_i,
	input  wire logic                               avs_write_i,
	input  wire logic [SAM_BE_W-1:0]                avs_byteenable_i,
	input  wire logic [SAM_DATA_W-1:0]              avs_writedata_i,
	input  wire logic [SAM_DATA_W-1:0]              avs_readdata_o,
	input  wire logic                               avs_waitrequest_o,
	input  wire sam_cond_in_s                       cond_i,
	input  wire logic [SAM_CHANS-1:0][SAM_RD_W-1:0] reading_i,
	input  wire logic [SAM_LINES-1:0]               alarm_line_o
);
	// All checks use the main clock and pause while reset is low.
	default clocking cb @(posedge mclk_i);
	endclocking
	default disable iff (!arst_n_i);

	// A request seen while idle is answered on the very next edge.
	a_req_answer: assert property (
		(avs_read_i || avs_write_i) && avs_waitrequest_o |=> !avs_waitrequest_o)
		else $error("request not answered next cycle");
	a_wait_one: assert property (
		!avs_waitrequest_o |=> avs_waitrequest_o)
		else $error("waitrequest low longer than one cycle");
	a_idle_wait: assert property (
		!avs_read_i && !avs_write_i && avs_waitrequest_o |=> avs_waitrequest_o)
		else $error("answer without a request");
	a_ack_cause: assert property (
		$fell(avs_waitrequest_o) |-> $past(avs_read_i || avs_write_i))
		else $error("waitrequest fell with no request before");
	a_reset_clear: assert property (
		$rose(arst_n_i) |-> alarm_line_o == '0 && avs_waitrequest_o)
		else $error("lines or waitrequest wrong after reset");
	// Quiet inputs and no writes for eight cycles leave the lines unchanged.
	a_lines_stable: assert property (
		(!avs_write_i && $stable(cond_i) && $stable(reading_i))[*8]
		|-> $stable(alarm_line_o))
		else $error("alarm lines moved with nothing changing");
	a_rdata_hold: assert property (
		avs_waitrequest_o |-> $stable(avs_readdata_o))
		else $error("read data changed outside an answer");
	a_unmap_zero: assert property (
		avs_read_i && !avs_waitrequest_o && avs_address_i >= 6'h38
		|-> avs_readdata_o == '0)
		else $error("unmapped read not zero");
endmodule : sam_alarm_mapper_chk

bind sam_alarm_mapper sam_alarm_mapper_chk u_chk (.mclk_i, .arst_n_i,
	.avs_address_i, .avs_read_i, .avs_write_i, .avs_byteenable_i,
	.avs_writedata_i, .avs_readdata_o, .avs_waitrequest_o, .cond_i,
	.reading_i, .alarm_line_o);

`default_nettype wire

// [test/sam_alarm_mapper_tb.sv]
// Self-checking testbench of the status alarm output mapper.
`timescale 1ns/1ns
`default_nettype none

module sam_alarm_mapper_tb
	import sam_pkg::*;
;
	typedef struct packed {
		logic [4:0]  sel;
		logic        pol;
		logic [13:0] cnd;
		logic        exp;
	} sam_row_s;

	logic                               mclk_i = 1'h0;
	logic                               arst_n_i = 1'h0;
	logic [SAM_ADDR_W-1:0]              avs_address_i = '0;
	logic                               avs_read_i = 1'h0;
	logic                               avs_write_i = 1'h0;
	logic [SAM_BE_W-1:0]                avs_byteenable_i = 4'hF;
	logic [SAM_DATA_W-1:0]              avs_writedata_i = '0;
	logic [SAM_DATA_W-1:0]              avs_readdata_o;
	logic                               avs_waitrequest_o;
	sam_cond_in_s                       cond_i = sam_cond_in_s'(14'h0100);
	logic [SAM_CHANS-1:0][SAM_RD_W-1:0] reading_i = '0;
	logic [SAM_LINES-1:0]               alarm_line_o;
	logic [SAM_LINES-1:0]               seen;
	logic [31:0]                        q;
	int                                 mismatches = 0;
	int                                 checked = 0;
	int                                 cyc = 0;
	logic [15:0]                        ovr_rd [4] = '{16'h0059, 16'h005A,
		16'h0051, 16'h0050};
	logic [3:0]                         ovr_ex = 4'h6;
	// Selector, polarity, condition pins and the line level they should give.
	sam_row_s rows [20] = '{
		'{5'h00, 1'h1, 14'h3FFF, 1'h0}, '{5'h01, 1'h1, 14'h0101, 1'h1},
		'{5'h02, 1'h1, 14'h0102, 1'h1}, '{5'h03, 1'h1, 14'h0104, 1'h1},
		'{5'h04, 1'h1, 14'h0108, 1'h1}, '{5'h05, 1'h1, 14'h0110, 1'h1},
		'{5'h06, 1'h1, 14'h0120, 1'h1}, '{5'h07, 1'h1, 14'h0140, 1'h1},
		'{5'h08, 1'h1, 14'h0180, 1'h1}, '{5'h09, 1'h1, 14'h0000, 1'h1},
		'{5'h0A, 1'h1, 14'h0300, 1'h1}, '{5'h0B, 1'h1, 14'h0500, 1'h1},
		'{5'h0C, 1'h1, 14'h0900, 1'h1}, '{5'h0D, 1'h1, 14'h1100, 1'h1},
		'{5'h0E, 1'h1, 14'h2100, 1'h1}, '{5'h0D, 1'h1, 14'h0104, 1'h1},
		'{5'h0B, 1'h0, 14'h0100, 1'h1}, '{5'h0B, 1'h0, 14'h0500, 1'h0},
		'{5'h09, 1'h1, 14'h0100, 1'h0}, '{5'h12, 1'h1, 14'h3FFF, 1'h0}};

	sam_alarm_mapper DUT (.mclk_i, .arst_n_i, .avs_address_i, .avs_read_i,
		.avs_write_i, .avs_byteenable_i, .avs_writedata_i, .avs_readdata_o,
		.avs_waitrequest_o, .cond_i, .reading_i, .alarm_line_o);
	sam_alarm_logger u_log (.mclk_i, .line_i(alarm_line_o), .seen_o(seen));

	// Free-running clock at 250 MHz.
	always #2 mclk_i = ~mclk_i;

	// One bus access, held until the edge that samples waitrequest low.
	// Only the bench timeout ends a wait that never sees an answer.
	task automatic bus(input logic w, input logic [5:0] a,
		input logic [31:0] d, output logic [31:0] r);
		@(posedge mclk_i);
		avs_address_i <= a;
		avs_writedata_i <= d;
		avs_write_i <= w;
		avs_read_i <= !w;
		do @(posedge mclk_i); while (avs_waitrequest_o !== 1'h0);
		r = avs_readdata_o;
		avs_read_i <= 1'h0;
		avs_write_i <= 1'h0;
	endtask : bus

	// Compares one value and reports a mismatch at once.
	task automatic chk(input string nm, input logic [31:0] e, g);
		checked++;
		if (g !== e)
		begin
			mismatches++;
			$display("[FAIL] %s expected %h seen %h", nm, e, g);
		end
	endtask : chk

	task automatic report_and_stop;
		if (mismatches == 0 && checked > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask : report_and_stop

	// Cuts a hang short well above the expected run length.
	always @(posedge mclk_i)
	begin
		cyc++;
		if (cyc == 5000)
		begin
			mismatches++;
			report_and_stop;
		end
	end

	// Main sequence: reset values, table rows, then hand-written cases.
	initial
	begin
		repeat (16) @(posedge mclk_i);
		arst_n_i <= 1'h1;
		chk("lines reset", 32'h0, 32'(alarm_line_o));
		bus(1'h0, SAM_OFF_CFG0, 32'h0, q);
		chk("cfg reset", 32'h0000_0100, q);
		bus(1'h0, SAM_OFF_RANGE0, 32'h0, q);
		chk("range reset", 32'h0000_FFFF, q);
		bus(1'h0, SAM_OFF_OVREN, 32'h0, q);
		chk("ovren reset", 32'h0000_0007, q);
		bus(1'h0, 6'h38, 32'h0, q);
		chk("unmapped", 32'h0, q);
		foreach (rows[i])
		begin
			bus(1'h1, 6'(4 * (i % 8)),
				{23'h0, rows[i].pol, 3'h0, rows[i].sel}, q);
			cond_i <= sam_cond_in_s'(rows[i].cnd);
			repeat (8) @(posedge mclk_i);
			chk("row line", 32'(rows[i].exp), 32'(seen[i % 8]));
		end
		bus(1'h0, 6'h0C, 32'h0, q);
		chk("cfg readback", 32'h0000_0112, q);
		cond_i <= sam_cond_in_s'(14'h0100);
		for (int c = 0; c < 3; c++)
		begin
			bus(1'h1, SAM_OFF_RANGE0 + 6'(4 * c), 32'h0064, q);
			bus(1'h1, 6'(4 * c), 32'(9'h100 + 9'(COND_OVR0) + 9'(c)), q);
			for (int k = 0; k < 4; k++)
			begin
				reading_i[c] <= ovr_rd[k];
				repeat (8) @(posedge mclk_i);
				chk("overrange", 32'(ovr_ex[k]), 32'(seen[c]));
			end
		end
		reading_i[2] <= 16'h005A;
		repeat (8) @(posedge mclk_i);
		chk("ovr2 set", 32'h1, 32'(seen[2]));
		bus(1'h0, SAM_OFF_CONDS, 32'h0, q);
		chk("conditions", 32'h0002_0000, q);
		bus(1'h1, SAM_OFF_LINES, 32'hFFFF_FFFF, q);
		bus(1'h0, SAM_OFF_LINES, 32'h0, q);
		chk("line status", 32'h0000_0404, q);
		bus(1'h1, SAM_OFF_OVREN, 32'h0000_0003, q);
		repeat (8) @(posedge mclk_i);
		chk("ovr2 disabled", 32'h0, 32'(seen[2]));
		avs_byteenable_i <= 4'h1;
		bus(1'h1, 6'h14, 32'h0000_000E, q);
		avs_byteenable_i <= 4'hF;
		bus(1'h0, 6'h14, 32'h0, q);
		chk("byte lanes", 32'h0000_010E, q);
		arst_n_i <= 1'h0;
		@(posedge mclk_i);
		chk("lines in reset", 32'h0, 32'(alarm_line_o));
		arst_n_i <= 1'h1;
		repeat (8) @(posedge mclk_i);
		chk("lines after reset", 32'h0, 32'(alarm_line_o));
		bus(1'h0, 6'h08, 32'h0, q);
		chk("cfg after reset", 32'h0000_0100, q);
		report_and_stop;
	end
endmodule : sam_alarm_mapper_tb

`default_nettype wire
